// ===== design/dplk_pkg.sv
// Package of constants for the dual pixel link mode and power-down block
package dplk_pkg;
    localparam int PIX_W = 24;
    localparam int CTL_W = 3;
    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PIXEL0 = 8'h08;
    localparam logic [7:0] OFS_PIXEL1 = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_RXPIX0 = 8'h14;
    localparam logic [7:0] OFS_RXPIX1 = 8'h18;
    // Config fields
    localparam int CFG_PDN = 0;
    localparam int CFG_EDGE = 1;
    localparam int CFG_POL = 2;
    localparam int CFG_MODE_LO = 3;
    localparam logic [4:0] CFG_RESET = 5'h00;
    // Pixel mode encodings
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DUAL = 2'h1;
    localparam logic [1:0] MODE_S2D = 2'h2;
    localparam logic [1:0] BRESP_OKAY = 2'h0;
    localparam logic [1:0] BRESP_SLVERR = 2'h2;
    localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
endpackage

// ===== design/dplk_top.sv
// Dual pixel link transmitter and receiver configuration and power-down
// Behaviour
// - In power-down the transmitter releases every serial link output.
// - In power-down the receiver drives its pixel and control outputs low.
// - Power-down stops the clock-multiplying PLL on both ends.
// - The strobe strap high takes inputs on rising edges, low on falling.
// - The polarity strap sets whether the active flag is high or low.
// - Dual mode takes two pixels per clock, 48 bits, on both link halves.
// - Single mode takes one 24-bit pixel per clock.
// - Single-to-dual mode pairs pixels from active start, odd to half A.
// - Single mode disables the second data half and the secondary clock.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dplk_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pixel_clock,
    input wire logic [47:0] pixel_in,
    input wire logic [2:0] ctrl_in,
    output logic [23:0] link_a_data,
    output logic link_a_oe_n,
    output logic [23:0] link_b_data,
    output logic link_b_oe_n,
    output logic link_clock,
    output logic link_clock_oe_n,
    output logic secondary_link_clock,
    output logic secondary_link_clock_oe_n,
    output logic link_ready,
    output logic [47:0] rx_pixel_out,
    output logic [2:0] rx_ctrl_out,
    output logic rx_clock_out,
    output logic pll_enable
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [4:0] cfg_reg;
    logic [47:0] wpix_reg;
    logic [2:0] wctl_reg;
    logic wpulse_reg;
    logic pdn;
    logic edge_sel;
    logic pol_sel;
    logic [1:0] mode;
    assign pdn = cfg_reg[dplk_pkg::CFG_PDN];
    assign edge_sel = cfg_reg[dplk_pkg::CFG_EDGE];
    assign pol_sel = cfg_reg[dplk_pkg::CFG_POL];
    assign mode = cfg_reg[dplk_pkg::CFG_MODE_LO +: 2];

    // AXI4-Lite write channel
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic wr_fire;
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
    assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dplk_pkg::BRESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
            end
            if (wr_fire)
            begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_reg == dplk_pkg::OFS_CONFIG
                    || awaddr_reg == dplk_pkg::OFS_PIXEL0
                    || awaddr_reg == dplk_pkg::OFS_PIXEL1
                    || awaddr_reg == dplk_pkg::OFS_CTRL)
                    s_axi_bresp <= dplk_pkg::BRESP_OKAY;
                else
                    s_axi_bresp <= dplk_pkg::BRESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes; straps change only in power-down
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_reg <= dplk_pkg::CFG_RESET;
            wpix_reg <= 48'h000000000000;
            wctl_reg <= 3'h0;
            wpulse_reg <= 1'b0;
        end
        else
        begin
            wpulse_reg <= 1'b0;
            if (wr_fire && awaddr_reg == dplk_pkg::OFS_CONFIG)
            begin
                cfg_reg[dplk_pkg::CFG_PDN] <= wdata_reg[0];
                if (!pdn)
                    cfg_reg[4:1] <= wdata_reg[4:1];
            end
            else if (wr_fire && awaddr_reg == dplk_pkg::OFS_PIXEL0)
                wpix_reg[23:0] <= wdata_reg[23:0];
            else if (wr_fire && awaddr_reg == dplk_pkg::OFS_PIXEL1)
                wpix_reg[47:24] <= wdata_reg[23:0];
            else if (wr_fire && awaddr_reg == dplk_pkg::OFS_CTRL)
            begin
                wctl_reg <= wdata_reg[2:0];
                wpulse_reg <= 1'b1;
            end
        end
    end

    // Pixel clock sync and edge select
    logic pclk_s1_reg;
    logic pclk_s2_reg;
    logic pclk_s3_reg;
    logic strobe;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pclk_s1_reg <= 1'b0;
            pclk_s2_reg <= 1'b0;
            pclk_s3_reg <= 1'b0;
        end
        else
        begin
            pclk_s1_reg <= pixel_clock;
            pclk_s2_reg <= pclk_s1_reg;
            pclk_s3_reg <= pclk_s2_reg;
        end
    end
    assign strobe = pdn && (edge_sel ? (pclk_s2_reg && !pclk_s3_reg)
                                     : (!pclk_s2_reg && pclk_s3_reg));

    // Parallel inputs pass two flip-flops
    logic [47:0] pix_s1_reg;
    logic [47:0] pix_s2_reg;
    logic [2:0] ctl_s1_reg;
    logic [2:0] ctl_s2_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pix_s1_reg <= 48'h000000000000;
            pix_s2_reg <= 48'h000000000000;
            ctl_s1_reg <= 3'h0;
            ctl_s2_reg <= 3'h0;
        end
        else
        begin
            pix_s1_reg <= pixel_in;
            pix_s2_reg <= pix_s1_reg;
            ctl_s1_reg <= ctrl_in;
            ctl_s2_reg <= ctl_s1_reg;
        end
    end

    // Capture and pixel pairing
    logic active;
    logic odd_reg;
    logic odd_valid_reg;
    logic [23:0] odd_pix_reg;
    logic cap_valid;
    logic [47:0] cap_pix;
    logic [2:0] cap_ctl;
    assign active = ctl_s2_reg[2] == pol_sel;
    always_comb
    begin
        cap_ctl = ctl_s2_reg;
        cap_valid = strobe;
        if (mode == dplk_pkg::MODE_DUAL)
            cap_pix = pix_s2_reg;
        else if (mode == dplk_pkg::MODE_S2D)
        begin
            cap_pix = {pix_s2_reg[23:0], odd_pix_reg};
            cap_valid = strobe && (!active || odd_valid_reg);
        end
        else
            cap_pix = {24'h000000, pix_s2_reg[23:0]};
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            odd_reg <= 1'b1;
            odd_valid_reg <= 1'b0;
            odd_pix_reg <= 24'h000000;
        end
        else if (strobe)
        begin
            if (!active)
            begin
                odd_reg <= 1'b1;
                odd_valid_reg <= 1'b0;
            end
            else if (odd_reg)
            begin
                odd_pix_reg <= pix_s2_reg[23:0];
                odd_valid_reg <= 1'b1;
                odd_reg <= 1'b0;
            end
            else
            begin
                odd_valid_reg <= 1'b0;
                odd_reg <= 1'b1;
            end
        end
    end

    // Two-entry buffer toward the link
    logic [50:0] buf_mem [0:1];
    logic [1:0] buf_cnt_reg;
    logic buf_wp_reg;
    logic buf_rp_reg;
    logic buf_in_ok;
    logic buf_out_ok;
    logic link_take;
    assign link_ready = buf_cnt_reg != 2'h2;
    assign buf_in_ok = cap_valid && link_ready;
    assign link_take = strobe;
    assign buf_out_ok = link_take && buf_cnt_reg != 2'h0;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !pdn)
        begin
            buf_cnt_reg <= 2'h0;
            buf_wp_reg <= 1'b0;
            buf_rp_reg <= 1'b0;
            buf_mem[0] <= 51'h0;
            buf_mem[1] <= 51'h0;
        end
        else
        begin
            if (buf_in_ok)
            begin
                buf_mem[buf_wp_reg] <= {cap_ctl, cap_pix};
                buf_wp_reg <= !buf_wp_reg;
            end
            if (buf_out_ok)
                buf_rp_reg <= !buf_rp_reg;
            buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_in_ok}
                - {1'b0, buf_out_ok};
        end
    end

    // Link drive and receiver side
    logic [50:0] head;
    assign head = buf_mem[buf_rp_reg];
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !pdn)
        begin
            link_a_data <= 24'h000000;
            link_b_data <= 24'h000000;
            rx_pixel_out <= 48'h000000000000;
            rx_ctrl_out <= 3'h0;
        end
        else if (buf_out_ok)
        begin
            link_a_data <= head[23:0];
            link_b_data <= head[47:24];
            rx_pixel_out <= head[47:0];
            rx_ctrl_out <= head[50:48];
        end
    end
    assign link_a_oe_n = !pdn;
    assign link_clock_oe_n = !pdn;
    assign link_b_oe_n = !pdn || mode == dplk_pkg::MODE_SINGLE;
    assign secondary_link_clock_oe_n = link_b_oe_n;
    assign link_clock = pdn && pclk_s2_reg;
    assign secondary_link_clock = link_clock;
    assign rx_clock_out = !pdn || pclk_s2_reg;
    assign pll_enable = pdn;

    // AXI4-Lite read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= dplk_pkg::BRESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= dplk_pkg::BRESP_OKAY;
            if (s_axi_araddr[7:0] == dplk_pkg::OFS_CONFIG)
                s_axi_rdata <= {27'h0, cfg_reg};
            else if (s_axi_araddr[7:0] == dplk_pkg::OFS_STATUS)
                s_axi_rdata <= {28'h0, buf_cnt_reg, odd_reg, pll_enable};
            else if (s_axi_araddr[7:0] == dplk_pkg::OFS_PIXEL0)
                s_axi_rdata <= {8'h00, wpix_reg[23:0]};
            else if (s_axi_araddr[7:0] == dplk_pkg::OFS_PIXEL1)
                s_axi_rdata <= {8'h00, wpix_reg[47:24]};
            else if (s_axi_araddr[7:0] == dplk_pkg::OFS_CTRL)
                s_axi_rdata <= {29'h0, wctl_reg};
            else if (s_axi_araddr[7:0] == dplk_pkg::OFS_RXPIX0)
                s_axi_rdata <= {8'h00, rx_pixel_out[23:0]};
            else if (s_axi_araddr[7:0] == dplk_pkg::OFS_RXPIX1)
                s_axi_rdata <= {8'h00, rx_pixel_out[47:24]};
            else
            begin
                s_axi_rdata <= dplk_pkg::READ_UNMAPPED;
                s_axi_rresp <= dplk_pkg::BRESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    assign s_axi_arready = !s_axi_rvalid;

    a_pd_release: assert property (
        !pdn |-> link_a_oe_n && link_b_oe_n && link_clock_oe_n)
        else $error("link driven in power-down");
    a_rx_low: assert property (
        !pdn |=> !pdn || (rx_pixel_out == 48'h0 && rx_ctrl_out == 3'h0))
        else $error("rx outputs not low in power-down");
    a_rx_clk_high: assert property (
        !pdn |-> rx_clock_out && !pll_enable)
        else $error("rx clock not high or pll running");
    a_pll_stop: assert property (pll_enable == pdn)
        else $error("pll state mismatch");
    a_strobe_edge: assert property (
        strobe |-> pdn && (pclk_s2_reg == edge_sel))
        else $error("strobe on wrong edge");
    a_single_off: assert property (
        mode == dplk_pkg::MODE_SINGLE |-> link_b_oe_n
        && secondary_link_clock_oe_n)
        else $error("second half driven in single mode");
    a_straps_static: assert property (
        $past(pdn) && pdn |-> $stable(cfg_reg[4:1]))
        else $error("strap changed while running");
    // Odd pixel taken, then held for its partner
    sequence s_odd_take;
        strobe && mode == dplk_pkg::MODE_S2D && active && odd_reg;
    endsequence
    sequence s_odd_held;
        odd_valid_reg && !odd_reg;
    endsequence
    a_pair_odd: assert property (s_odd_take |=> s_odd_held)
        else $error("odd pixel not held");
    a_buf_bound: assert property (buf_cnt_reg <= 2'h2)
        else $error("buffer overflow");
endmodule
`default_nettype wire

// ===== verif/dplk_pixel_source.sv
// Pixel source model driving the parallel side of the link block
`timescale 1ns/1ps
`default_nettype none
module dplk_pixel_source
(
    input wire logic run,
    input wire logic edge_rise,
    input wire logic s2d,
    input wire logic flag_on,
    input wire logic [23:0] pat_a,
    input wire logic [23:0] pat_b,
    output logic pixel_clock,
    output logic [47:0] pixel_in,
    output logic [2:0] ctrl_in
);
    logic odd;
    int cnt;
    initial
    begin
        pixel_clock = 1'b0;
        pixel_in = 48'h0;
        ctrl_in = 3'h0;
        odd = 1'b1;
        cnt = 0;
        forever
        begin
            #400;
            if (run)
            begin
                pixel_clock = ~pixel_clock;
                // Launch on the edge opposite the capture edge
                if (pixel_clock != edge_rise)
                begin
                    ctrl_in = {(cnt < 16) ? flag_on : ~flag_on, 2'h1};
                    // Two blanking strobes per line keep pairs aligned
                    cnt = (cnt == 17) ? 0 : cnt + 1;
                    pixel_in = s2d ? {24'h0, odd ? pat_a : pat_b}
                                   : {pat_b, pat_a};
                    odd = ~odd;
                end
            end
            else
            begin
                // Clock stands still outside frames
                pixel_clock = 1'b0;
                ctrl_in = {~flag_on, 2'h0};
                odd = 1'b1;
                cnt = 0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb_dplk_top.sv
// Testbench for the link mode and power-down block
`timescale 1ns/1ps
`default_nettype none
module tb_dplk_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pclk, run, edge_rise, s2d;
    logic flag_on, la_oe_n, lb_oe_n, lclk, lclk_oe_n, sclk, sclk_oe_n;
    logic lrdy, rxclk, pll;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic [31:0] a_cfg, a_sts, cw;
    logic [3:0] oe;
    logic sgl;
    int w;
    logic [1:0] bresp, rresp, r;
    logic [23:0] pat_a, pat_b, la, lb;
    logic [47:0] pin, rxp;
    logic [2:0] cin, rxc;
    logic [1:0] md [4] = '{dplk_pkg::MODE_DUAL, dplk_pkg::MODE_SINGLE,
                          dplk_pkg::MODE_S2D, dplk_pkg::MODE_DUAL};
    logic [3:0] pl = 4'b0111;
    logic [3:0] eg = 4'b1101;
    int n_fail, check_count, cyc;
    dplk_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pixel_clock(pclk), .pixel_in(pin),
        .ctrl_in(cin), .link_a_data(la), .link_a_oe_n(la_oe_n),
        .link_b_data(lb), .link_b_oe_n(lb_oe_n), .link_clock(lclk),
        .link_clock_oe_n(lclk_oe_n), .secondary_link_clock(sclk),
        .secondary_link_clock_oe_n(sclk_oe_n), .link_ready(lrdy),
        .rx_pixel_out(rxp), .rx_ctrl_out(rxc), .rx_clock_out(rxclk),
        .pll_enable(pll));
    dplk_pixel_source i_src (.run(run), .edge_rise(edge_rise), .s2d(s2d),
        .flag_on(flag_on), .pat_a(pat_a), .pat_b(pat_b),
        .pixel_clock(pclk), .pixel_in(pin), .ctrl_in(cin));
    assign oe = {la_oe_n, lb_oe_n, lclk_oe_n, sclk_oe_n};
    task automatic test_done();
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [47:0] e,
                       input logic [47:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        int k;
        k = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 50);
        r = bresp;
        if (k >= 50)
            chk("write answer", 48'h1, 48'h0);
    endtask
    task automatic rd(input logic [31:0] a);
        int k;
        k = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 50);
        d = rdata;
        r = rresp;
        if (k >= 50)
            chk("read answer", 48'h1, 48'h0);
    endtask
    task automatic pd_check();
        chk("oe_n", 48'hF, 48'(oe));
        chk("rx outputs", 48'h0, {rxc, rxp});
        chk("rx clock", 48'h1, rxclk);
        chk("pll", 48'h0, pll);
    endtask
    initial
    begin
        aclk = 1'b0;
        forever
            #50 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            n_fail++;
            test_done();
        end
    end
    initial
    begin
        {aresetn, awvalid, wvalid, arvalid, run} = 5'h0;
        // Response ready stays high: every answer is taken when offered
        {bready, rready} = 2'h3;
        {awaddr, wdata, araddr, cw} = 128'h0;
        {edge_rise, s2d, flag_on, pat_a, pat_b} = 51'h0;
        a_cfg = {24'h00, dplk_pkg::OFS_CONFIG};
        a_sts = {24'h00, dplk_pkg::OFS_STATUS};
        sgl = 1'b0;
        w = 0;
        n_fail = 0;
        check_count = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        pd_check();
        rd(a_cfg);
        chk("config reset", 48'(dplk_pkg::CFG_RESET), 48'(d));
        rd(32'h40);
        chk("unmapped rresp", 48'(dplk_pkg::BRESP_SLVERR), 48'(r));
        chk("unmapped rdata", 48'(dplk_pkg::READ_UNMAPPED), 48'(d));
        wr(32'h40, 32'h5);
        chk("unmapped bresp", 48'(dplk_pkg::BRESP_SLVERR), 48'(r));
        for (int i = 0; i < 4; i++)
        begin
            cw = {27'h0, md[i], pl[i], eg[i], 1'b0};
            sgl = (md[i] == dplk_pkg::MODE_SINGLE);
            pat_a <= 24'hA51000 + 24'(i);
            pat_b <= 24'h3C2000 + 24'(i);
            wr(a_cfg, cw);
            edge_rise <= eg[i];
            s2d <= (md[i] == dplk_pkg::MODE_S2D);
            flag_on <= pl[i];
            wr(a_cfg, cw | 32'h1);
            run <= 1'b1;
            repeat (320) @(posedge aclk);
            // Look at the link only while it carries active pixels
            w = 0;
            while (rxc[2] !== pl[i] && w < 300)
            begin
                @(posedge aclk);
                w++;
            end
            chk("half a", 48'(pat_a), 48'(la));
            if (md[i] != dplk_pkg::MODE_SINGLE)
                chk("half b", 48'(pat_b), 48'(lb));
            chk("link ready", 48'h1, 48'(lrdy));
            rd(a_cfg);
            chk("config", 48'(cw | 32'h1), 48'(d));
            chk("pll on", 48'h1, 48'(pll));
            chk("oe_n on", {44'h0, 1'b0, sgl, 1'b0, sgl}, 48'(oe));
            rd(a_sts);
            chk("status pll", 48'h1, 48'(d[0]));
            // Strap bits written while running must be ignored
            wr(a_cfg, {27'h0, ~cw[4:1], 1'b1});
            rd(a_cfg);
            chk("straps locked", 48'(cw | 32'h1), 48'(d));
            wr(a_cfg, cw);
            run <= 1'b0;
            repeat (4) @(posedge aclk);
            pd_check();
        end
        test_done();
    end
endmodule
`default_nettype wire
